// File: hdl/msg_gpio_regs.svh
// Register offsets, reset values and field positions of the GPIO ports.
`ifndef MSG_GPIO_REGS_SVH
`define MSG_GPIO_REGS_SVH

// ************************************************************
// Register offsets on the plain register port.
// ************************************************************
`define MSG_ADDR_PORT_A     8'h05
`define MSG_ADDR_PORT_B     8'h06
`define MSG_ADDR_OPTION     8'h81
`define MSG_ADDR_DIR_A      8'h85
`define MSG_ADDR_DIR_B      8'h86
`define MSG_ADDR_IRQ_CTRL   8'h8B
`define MSG_ADDR_PULLUP_B   8'h95
`define MSG_ADDR_CHG_EN_B   8'h96
`define MSG_ADDR_ANALOG     8'h9D

// ************************************************************
// Reset values.
// ************************************************************
`define MSG_RST_ALL_ONES    8'hFF
`define MSG_RST_ZERO        8'h00
`define MSG_RST_CHG_EN_B    8'hF0
`define MSG_RST_OPTION      8'hFF

// ************************************************************
// Field positions.
// ************************************************************
`define MSG_BIT_PU_DIS_N    7
`define MSG_BIT_GIE         7
`define MSG_BIT_PCE         3
`define MSG_BIT_PCF         0
`define MSG_BIT_OSC_OUT     6
`define MSG_BIT_OSC_IN      7
`define MSG_BIT_OPEN_DRAIN  4
`define MSG_MASK_IN_ONLY_A  8'h23
`define MSG_MASK_ANALOG_A   8'h0F

`endif

// File: hdl/msg_pkg.sv
// Types shared by the GPIO port design.
package msg_pkg;

  // Oscillator configuration word selections.
  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL   = 3'h0,
    OSC_STD_CRYSTAL         = 3'h1,
    OSC_HIGH_SPEED_CRYSTAL  = 3'h2,
    OSC_RES_CAP_CLOCK_OUT_QUARTER      = 3'h3,
    OSC_RES_CAP_NO_CLOCK_OUT_QUARTER   = 3'h4,
    OSC_INTERNAL_CLOCK_OUT_QUARTER     = 3'h5,
    OSC_INTERNAL_NO_CLOCK_OUT_QUARTER  = 3'h6,
    OSC_EXTERNAL_CLOCK      = 3'h7
  } msg_osc_e;

  // One port byte.
  typedef logic [7:0] msg_byte_t;

endpackage : msg_pkg

// File: hdl/msg_gpio_ports.sv
// Two 8-bit mixed-signal GPIO ports with pull-ups and change detection.
// Operation
// [RQ1] Port A direction gates driver, analog kills input
// [RQ2] Software programs both direction and analog select
// [RQ3] Analog pin reads zero, else pin level
// [RQ4] Crystal modes ignore bit 6 direction, read zero
// [RQ5] Bit 6 clock out, oscillator or digital
// [RQ6] Bit 7 oscillator or clock input, or digital
// [RQ7] Reset loads direction A and analog all ones
// [RQ8] Port B direction one floats, zero drives latch
// [RQ9] Analog bits 4..7 select port B 0..3
// [RQ10] Peripheral outputs replace latch on pins 6,7
// [RQ11] Pull-up needs select bit and global enable
// [RQ12] Output pins never get a pull-up
// [RQ13] Pull-ups disabled after power-on reset
// [RQ14] Only enabled inputs join change detection
// [RQ15] Mismatch against old latch sets change flag
// [RQ16] Interrupt needs change enable and global enable
// [RQ17] Mismatch wakes device from sleep
// [RQ18] Port B access recopies comparison latch
// [RQ19] Handler accesses port B, then clears flag
// [RQ20] Pull-up select at 95h, resets all ones
// [RQ21] Change enable at 96h, resets F0h
// [RQ22] Port writes are read-modify-write
// [RQ23] Pins pass a two-stage synchronizer
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "msg_gpio_regs.svh"

module msg_gpio_ports
  import msg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  input  wire msg_osc_e   osc_mode,
  input  wire logic       timer1_osc_enable,
  input  wire logic [1:0] periph_out_en,
  input  wire logic [1:0] periph_out,
  input  wire logic [7:0] port_a_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe,
  input  wire logic [7:0] port_b_in,
  output logic      [7:0] port_b_out,
  output logic      [7:0] port_b_oe,
  output logic      [7:0] pullup_b_en,
  output logic            port_change_irq,
  output logic            port_change_wake
);

  // ************************************************************
  // Register state.
  // ************************************************************
  msg_byte_t lat_a;          // Port A output latch.
  msg_byte_t lat_b;          // Port B output latch.
  msg_byte_t pin_direction_a; // One makes a port A pin an input.
  msg_byte_t pin_direction_b; // One makes a port B pin an input.
  msg_byte_t analog_select;   // One turns a pin analog.
  msg_byte_t pullup_select_b; // Per-pin pull-up select.
  msg_byte_t change_irq_enable_b; // Per-pin change enable.
  msg_byte_t option_rest;     // Other option bits, storage only.
  logic      pullup_global_disable_n; // Low enables pull-ups.
  logic      global_irq_enable;    // Global interrupt enable.
  logic      port_change_enable;   // Port change interrupt enable.
  logic      port_change_flag;     // Sticky change flag.
  logic [3:0] irq_ctrl_rest;       // Other control bits, storage.
  msg_byte_t old_b;          // Pin copy from the last port B access.
  msg_byte_t sync1_a;        // First synchronizer stage, port A.
  msg_byte_t sync2_a;        // Second synchronizer stage, port A.
  msg_byte_t sync1_b;        // First synchronizer stage, port B.
  msg_byte_t sync2_b;        // Second synchronizer stage, port B.
  logic [1:0] clk_div;       // Quarter-rate clock divider.

  // ************************************************************
  // Decoded strobes and derived views.
  // ************************************************************
  logic      wr_a;           // Write to port A.
  logic      wr_b;           // Write to port B.
  logic      access_b;       // Any access to port B.
  logic      crystal;        // A crystal oscillator is selected.
  logic      pin6_digital;   // Bit 6 acts as digital I/O.
  logic      pin6_clock_out_quarter;    // Bit 6 drives the quarter clock.
  logic      pin7_digital;   // Bit 7 acts as digital I/O.
  msg_byte_t analog_a;       // Port A pins in analog mode.
  msg_byte_t analog_b;       // Port B pins in analog mode.
  msg_byte_t read_a;         // Value that a port A read returns.
  msg_byte_t read_b;         // Value that a port B read returns.
  msg_byte_t watch_b;        // Pins taking part in detection.
  logic      mismatch;       // Any watched pin differs.
  msg_byte_t next_rdata;     // Read data for the next cycle.

  assign wr_a     = wr_en && (addr == `MSG_ADDR_PORT_A);
  assign wr_b     = wr_en && (addr == `MSG_ADDR_PORT_B);
  assign access_b = (wr_en || rd_en) && (addr == `MSG_ADDR_PORT_B);
  // Crystal modes own bit 6 as the feedback pin.
  assign crystal = (osc_mode == OSC_LOW_POWER_CRYSTAL) ||
                   (osc_mode == OSC_STD_CRYSTAL) ||
                   (osc_mode == OSC_HIGH_SPEED_CRYSTAL);

  // ************************************************************
  // Oscillator pin functions.
  // ************************************************************
  // Bit 6 and bit 7 take their role from the oscillator selection.
  always_comb begin
    pin6_digital = 1'b0;
    pin6_clock_out_quarter  = 1'b0;
    pin7_digital = 1'b0;
    case (osc_mode)
      OSC_RES_CAP_CLOCK_OUT_QUARTER,
      OSC_INTERNAL_CLOCK_OUT_QUARTER: begin
        pin6_clock_out_quarter  = 1'b1;                                 // RQ5
        pin7_digital = (osc_mode == OSC_INTERNAL_CLOCK_OUT_QUARTER) &&
                       !timer1_osc_enable;                   // RQ6
      end
      OSC_INTERNAL_NO_CLOCK_OUT_QUARTER: begin
        pin6_digital = !timer1_osc_enable;                   // RQ5
        pin7_digital = !timer1_osc_enable;                   // RQ6
      end
      OSC_RES_CAP_NO_CLOCK_OUT_QUARTER,
      OSC_EXTERNAL_CLOCK: begin
        pin6_digital = 1'b1;                                 // RQ5
      end
      default: pin6_digital = 1'b0;                          // RQ4
    endcase
  end

  // ************************************************************
  // Pin synchronizers.
  // ************************************************************
  // Two flops per pin; only the second stage feeds any logic.
  always_ff @(posedge clk) begin
    sync1_a <= port_a_in;                                    // RQ23
    sync2_a <= sync1_a;
    sync1_b <= port_b_in;                                    // RQ23
    sync2_b <= sync1_b;
  end

  // Quarter-rate clock output divider.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_div <= 2'h0;
    end else begin
      clk_div <= clk_div + 2'h1;
    end
  end

  // ************************************************************
  // Read views of the pins.
  // ************************************************************
  // Analog pins have their input buffer off and read as zero.
  assign analog_a = analog_select & `MSG_MASK_ANALOG_A;      // RQ1
  assign analog_b = {4'h0, analog_select[7:4]};              // RQ9

  // Port A read masks analog pins and oscillator-owned pins.
  always_comb begin
    read_a = sync2_a & ~analog_a;                            // RQ3
    if (!pin6_digital) read_a[`MSG_BIT_OSC_OUT] = 1'b0;      // RQ4
    if (!pin7_digital) read_a[`MSG_BIT_OSC_IN] = 1'b0;       // RQ6
  end
  assign read_b = sync2_b & ~analog_b;                       // RQ3

  // ************************************************************
  // Port A drivers.
  // ************************************************************
  // Input-only pins never drive; the open-drain pin only pulls low.
  always_comb begin
    port_a_out = lat_a;
    port_a_oe  = ~pin_direction_a & ~`MSG_MASK_IN_ONLY_A;    // RQ1
    port_a_out[`MSG_BIT_OPEN_DRAIN] = 1'b0;
    port_a_oe[`MSG_BIT_OPEN_DRAIN] =
      !pin_direction_a[`MSG_BIT_OPEN_DRAIN] && !lat_a[`MSG_BIT_OPEN_DRAIN];
    if (pin6_clock_out_quarter) begin
      port_a_out[`MSG_BIT_OSC_OUT] = clk_div[1];             // RQ5
      port_a_oe[`MSG_BIT_OSC_OUT]  = 1'b1;
    end else if (!pin6_digital) begin
      port_a_oe[`MSG_BIT_OSC_OUT]  = 1'b0;                   // RQ4
    end
    if (!pin7_digital) port_a_oe[`MSG_BIT_OSC_IN] = 1'b0;    // RQ6
  end

  // ************************************************************
  // Port B drivers and pull-ups.
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_port_b
      if (gi >= 6) begin : g_periph
        // A peripheral replaces the latch but not the direction.
        assign port_b_out[gi] = periph_out_en[gi-6] ?
                                periph_out[gi-6] : lat_b[gi]; // RQ10
      end else begin : g_plain
        assign port_b_out[gi] = lat_b[gi];                   // RQ8
      end
      assign port_b_oe[gi] = !pin_direction_b[gi];           // RQ8
      // Pull-up only on inputs with select set and global enable.
      assign pullup_b_en[gi] = pullup_select_b[gi] &&
                               !pullup_global_disable_n &&
                               pin_direction_b[gi];          // RQ11 RQ12
      // Only enabled inputs are watched for change.
      assign watch_b[gi] = pin_direction_b[gi] &&
                           change_irq_enable_b[gi];          // RQ14
    end
  endgenerate

  // ************************************************************
  // Change detection.
  // ************************************************************
  assign mismatch = |((read_b ^ old_b) & watch_b);           // RQ15
  // Comparison latch follows every port B read or write.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      old_b <= `MSG_RST_ZERO;
    end else if (access_b) begin
      old_b <= read_b;                                       // RQ18
    end
  end

  // The flag is set while a mismatch lasts; set beats a clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_change_flag <= 1'b0;
    end else if (mismatch) begin
      port_change_flag <= 1'b1;                              // RQ15
    end else if (wr_en && (addr == `MSG_ADDR_IRQ_CTRL)) begin
      port_change_flag <= wdata[`MSG_BIT_PCF];
    end
  end

  assign port_change_irq = port_change_flag && port_change_enable &&
                           global_irq_enable;                // RQ16
  // Wake needs the change enable but not the global enable.
  assign port_change_wake = mismatch && port_change_enable;  // RQ17

  // ************************************************************
  // Port latches.
  // ************************************************************
  // A full-byte write modifies every bit, so the latch takes wdata.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lat_a <= `MSG_RST_ZERO;
      lat_b <= `MSG_RST_ZERO;
    end else begin
      if (wr_a) lat_a <= wdata;                              // RQ22
      if (wr_b) lat_b <= wdata;                              // RQ22
    end
  end

  // ************************************************************
  // Configuration registers.
  // ************************************************************
  // Direction A bit 6 is frozen while a crystal owns it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_direction_a <= `MSG_RST_ALL_ONES;                  // RQ7
      pin_direction_b <= `MSG_RST_ALL_ONES;
      analog_select   <= `MSG_RST_ALL_ONES;                  // RQ7
    end else if (wr_en) begin
      case (addr)
        `MSG_ADDR_DIR_A: begin
          pin_direction_a <= wdata;
          if (crystal) begin
            pin_direction_a[`MSG_BIT_OSC_OUT] <=
              pin_direction_a[`MSG_BIT_OSC_OUT];             // RQ4
          end
        end
        `MSG_ADDR_DIR_B: begin
          pin_direction_b <= wdata;
        end
        `MSG_ADDR_ANALOG: begin
          analog_select <= wdata;
        end
        default: analog_select <= analog_select;
      endcase
    end
  end

  // Pull-up, change enable and option storage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pullup_select_b         <= `MSG_RST_ALL_ONES;          // RQ20
      change_irq_enable_b     <= `MSG_RST_CHG_EN_B;          // RQ21
      option_rest             <= `MSG_RST_OPTION;
      pullup_global_disable_n <= 1'b1;                       // RQ13
    end else if (wr_en) begin
      case (addr)
        `MSG_ADDR_PULLUP_B: begin
          pullup_select_b <= wdata;                          // RQ20
        end
        `MSG_ADDR_CHG_EN_B: begin
          change_irq_enable_b <= wdata;                      // RQ21
        end
        `MSG_ADDR_OPTION: begin
          option_rest             <= wdata;
          pullup_global_disable_n <= wdata[`MSG_BIT_PU_DIS_N];
        end
        default: option_rest <= option_rest;
      endcase
    end
  end

  // Interrupt control bits other than the change flag.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      global_irq_enable  <= 1'b0;
      port_change_enable <= 1'b0;
      irq_ctrl_rest      <= 4'h0;
    end else if (wr_en && (addr == `MSG_ADDR_IRQ_CTRL)) begin
      global_irq_enable  <= wdata[`MSG_BIT_GIE];
      port_change_enable <= wdata[`MSG_BIT_PCE];
      irq_ctrl_rest      <= {wdata[6:4], wdata[2]};
    end
  end

  // ************************************************************
  // Read-back.
  // ************************************************************
  // Unmapped offsets read zero; data stands for one cycle only.
  always_comb begin
    next_rdata = `MSG_RST_ZERO;
    case (addr)
      `MSG_ADDR_PORT_A:   next_rdata = read_a;
      `MSG_ADDR_PORT_B:   next_rdata = read_b;
      `MSG_ADDR_DIR_A:    next_rdata = pin_direction_a;
      `MSG_ADDR_DIR_B:    next_rdata = pin_direction_b;
      `MSG_ADDR_ANALOG:   next_rdata = analog_select;
      `MSG_ADDR_PULLUP_B: next_rdata = pullup_select_b;
      `MSG_ADDR_CHG_EN_B: next_rdata = change_irq_enable_b;
      `MSG_ADDR_OPTION:   next_rdata = {pullup_global_disable_n,
                                        option_rest[6:0]};
      `MSG_ADDR_IRQ_CTRL: next_rdata = {global_irq_enable,
                                        irq_ctrl_rest[3:1],
                                        port_change_enable,
                                        irq_ctrl_rest[0], 1'b0,
                                        port_change_flag};
      default:            next_rdata = `MSG_RST_ZERO;
    endcase
  end

  // Read data register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= `MSG_RST_ZERO;
    end else if (rd_en) begin
      rdata <= next_rdata;
    end else begin
      rdata <= `MSG_RST_ZERO;
    end
  end

  // ************************************************************
  // Assertions.
  // ************************************************************
  sequence seq_read_a;
    rd_en && (addr == `MSG_ADDR_PORT_A);
  endsequence
  sequence seq_mismatch;
    mismatch;
  endsequence
  AST_DRIVER_A: assert property (@(posedge clk) disable iff (!rst_n) // RQ1
    pin_direction_a[2] |-> !port_a_oe[2])
    else $error("Port A input pin is driven.");
  AST_ANALOG_READ: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    seq_read_a and analog_select[0] |=> !rdata[0])
    else $error("Analog port A pin did not read zero.");
  AST_XTAL_DIR: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    crystal && wr_en && (addr == `MSG_ADDR_DIR_A) |=> $stable(pin_direction_a[6]))
    else $error("Direction bit 6 changed in crystal mode.");
  AST_CLOCK_OUT_QUARTER: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
    pin6_clock_out_quarter |-> port_a_oe[6] && (port_a_out[6] == clk_div[1]))
    else $error("Clock output not on bit 6.");
  AST_OSC_IN: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
    (crystal || osc_mode == OSC_EXTERNAL_CLOCK) |-> !port_a_oe[7])
    else $error("Oscillator input pin is driven.");
  AST_RESET: assert property (@(posedge clk) // RQ7
    !rst_n |=> (pin_direction_a == `MSG_RST_ALL_ONES) && (analog_select == `MSG_RST_ALL_ONES))
    else $error("Direction A or analog select not all ones after reset.");
  AST_DRIVER_B: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    !pin_direction_b[0] |-> port_b_oe[0] && (port_b_out[0] == lat_b[0]))
    else $error("Port B output pin does not drive its latch.");
  AST_PERIPH: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
    periph_out_en[1] |-> (port_b_out[7] == periph_out[1]))
    else $error("Peripheral did not replace the latch on bit 7.");
  AST_PULLUP: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
    pullup_b_en[3] |-> pin_direction_b[3] && !pullup_global_disable_n)
    else $error("Pull-up on while disabled or on an output.");
  AST_FLAG: assert property (@(posedge clk) disable iff (!rst_n) // RQ15
    seq_mismatch |=> port_change_flag)
    else $error("Mismatch did not set the change flag.");
  AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n) // RQ16
    port_change_irq |-> global_irq_enable && port_change_enable)
    else $error("Change interrupt without both enables.");
  AST_COPY: assert property (@(posedge clk) disable iff (!rst_n) // RQ18
    access_b |=> (old_b == $past(read_b)))
    else $error("Port B access did not recopy the latch.");

endmodule : msg_gpio_ports

// File: testbench/msg_gpio_ports_tb.sv
// Self-checking testbench for the two mixed-signal GPIO ports.
`timescale 1ns/100ps
`include "msg_gpio_regs.svh"

module msg_gpio_ports_tb;
  import msg_pkg::*;

  // ************************************************************
  // Signals around the unit under test.
  // ************************************************************
  logic       clk;               // Core clock, 50 ns period.
  logic       rst_n;             // Synchronous reset, active low.
  logic [7:0] addr;              // Register offset.
  logic [7:0] wdata;             // Write data.
  logic       wr_en;             // Write strobe.
  logic       rd_en;             // Read strobe.
  logic [7:0] rdata;             // Read data, one cycle after the strobe.
  msg_osc_e   osc_mode;          // Oscillator selection.
  logic       timer1_osc_enable; // Timer-1 oscillator on the clock pins.
  logic [1:0] periph_out_en;     // Peripheral drive enables for pins 6 and 7.
  logic [1:0] periph_out;        // Peripheral drive values.
  logic [7:0] port_a_in;         // Port A pin levels.
  logic [7:0] port_a_out;        // Port A drive values.
  logic [7:0] port_a_oe;         // Port A driver enables.
  logic [7:0] port_b_in;         // Port B pin levels.
  logic [7:0] port_b_out;        // Port B drive values.
  logic [7:0] port_b_oe;         // Port B driver enables.
  logic [7:0] pullup_b_en;       // Port B pull-up enables.
  logic       port_change_irq;   // Change interrupt to the core.
  logic       port_change_wake;  // Change wake request.
  int         mismatches;        // Failed comparisons.
  int         checked;           // Comparisons made.
  int         cycles;            // Watchdog on the whole run.
  msg_byte_t  d;                 // Last value read back.

  msg_gpio_ports uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .osc_mode(osc_mode), .timer1_osc_enable(timer1_osc_enable),
    .periph_out_en(periph_out_en), .periph_out(periph_out), .port_a_in(port_a_in),
    .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_in(port_b_in),
    .port_b_out(port_b_out), .port_b_oe(port_b_oe), .pullup_b_en(pullup_b_en),
    .port_change_irq(port_change_irq), .port_change_wake(port_change_wake));

  // ************************************************************
  // Clock, watchdog and shared tasks.
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hung bus or wait would stall forever, so the run is cut off here.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string n, input msg_byte_t e, input msg_byte_t g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One-cycle write strobe beside address and data.
  task automatic wr(input msg_byte_t a, input msg_byte_t v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input msg_byte_t a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Lets the last register update land before outputs are judged.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic t_reset();
    settle(1);
    chk("oe_a", 8'h00, port_a_oe);
    chk("oe_b", 8'h00, port_b_oe);
    chk("pullup", 8'h00, pullup_b_en);
    rd(`MSG_ADDR_DIR_A);  chk("dir_a", 8'hFF, d);
    rd(`MSG_ADDR_ANALOG); chk("analog", 8'hFF, d);
    rd(`MSG_ADDR_PULLUP_B); chk("pu_sel", 8'hFF, d);
    rd(`MSG_ADDR_CHG_EN_B); chk("chg_en", 8'hF0, d);
    settle(1);
    chk("rdata_idle", 8'h00, rdata);
    wr(8'h10, 8'h5A);
    rd(8'h10); chk("unmapped", 8'h00, d);
  endtask : t_reset

  // Analog pins read zero whatever the pin shows.
  task automatic t_analog();
    port_a_in <= 8'hFF;
    port_b_in <= 8'hFF;
    settle(3);
    rd(`MSG_ADDR_PORT_A); chk("a_analog", 8'h70, d);
    rd(`MSG_ADDR_PORT_B); chk("b_analog", 8'hF0, d);
    wr(`MSG_ADDR_ANALOG, 8'h6F);
    rd(`MSG_ADDR_PORT_B); chk("b_mixed", 8'hF9, d);
    wr(`MSG_ADDR_ANALOG, 8'h00);
    rd(`MSG_ADDR_PORT_A); chk("a_digital", 8'h7F, d);
  endtask : t_analog

  // Every oscillator mode, timer-1 oscillator off and on.
  task automatic t_osc();
    logic b6, b7;
    for (int m = 0; m < 8; m++) begin
      for (int t = 0; t < 2; t++) begin
        osc_mode <= msg_osc_e'(m);
        timer1_osc_enable <= t[0];
        b6 = (m == 4) || (m == 7) || (m == 6 && t == 0);
        b7 = (m == 5 || m == 6) && t == 0;
        rd(`MSG_ADDR_PORT_A); chk("osc_read", {b7, b6, 6'h3F}, d);
      end
    end
    osc_mode <= OSC_LOW_POWER_CRYSTAL;
    wr(`MSG_ADDR_DIR_A, 8'h00);
    rd(`MSG_ADDR_DIR_A); chk("dir_a_xtal", 8'h40, d);
    osc_mode <= OSC_EXTERNAL_CLOCK;
    wr(`MSG_ADDR_DIR_A, 8'h00);
    wr(`MSG_ADDR_PORT_A, 8'h0C);
    settle(1);
    chk("oe_a_low", 8'h1C, port_a_oe & 8'h3F);
    chk("out_a", 8'h0C, port_a_out & 8'h0C);
    wr(`MSG_ADDR_DIR_A, 8'hFF);
    settle(1);
    chk("oe_a_off", 8'h00, port_a_oe & 8'h3F);
    // The quarter-rate clock must flip every two core cycles.
    osc_mode <= OSC_RES_CAP_CLOCK_OUT_QUARTER;
    settle(2);
    d = {7'h00, port_a_out[6]};
    settle(2);
    chk("clock_out_quarter", {7'h01, ~d[0]}, {6'h00, port_a_oe[6], port_a_out[6]});
  endtask : t_osc

  // Port B drivers, peripheral override and pull-ups.
  task automatic t_port_b();
    wr(`MSG_ADDR_DIR_B, 8'h00);
    wr(`MSG_ADDR_PORT_B, 8'h5A);
    settle(1);
    chk("oe_b_on", 8'hFF, port_b_oe);
    chk("out_b", 8'h5A, port_b_out);
    periph_out_en <= 2'b11;
    periph_out    <= 2'b10;
    settle(1);
    chk("out_b_per", 8'h9A, port_b_out);
    wr(`MSG_ADDR_DIR_B, 8'hFF);
    settle(1);
    chk("oe_b_off", 8'h00, port_b_oe);
    wr(`MSG_ADDR_OPTION, 8'h7F);
    settle(1);
    chk("pu_all", 8'hFF, pullup_b_en);
    wr(`MSG_ADDR_PULLUP_B, 8'h0F);
    wr(`MSG_ADDR_DIR_B, 8'hF3);
    settle(1);
    chk("pu_sel_dir", 8'h03, pullup_b_en);
    wr(`MSG_ADDR_OPTION, 8'hFF);
    settle(1);
    chk("pu_global", 8'h00, pullup_b_en);
  endtask : t_port_b

  // Change detection, interrupt gating and the clearing order.
  task automatic t_change();
    wr(`MSG_ADDR_DIR_B, 8'hEF);
    wr(`MSG_ADDR_IRQ_CTRL, 8'h88);
    rd(`MSG_ADDR_PORT_B);
    port_b_in <= 8'hFE;
    settle(5);
    chk("no_en_pin", 8'h00, {7'h00, port_change_irq});
    port_b_in <= 8'hEE;
    settle(5);
    chk("out_pin", 8'h00, {7'h00, port_change_wake});
    port_b_in <= 8'hCE;
    settle(5);
    chk("wake", 8'h01, {7'h00, port_change_wake});
    chk("irq", 8'h01, {7'h00, port_change_irq});
    rd(`MSG_ADDR_PORT_B);
    settle(2);
    chk("wake_end", 8'h00, {7'h00, port_change_wake});
    chk("irq_held", 8'h01, {7'h00, port_change_irq});
    wr(`MSG_ADDR_IRQ_CTRL, 8'h88);
    settle(1);
    chk("irq_clr", 8'h00, {7'h00, port_change_irq});
    wr(`MSG_ADDR_IRQ_CTRL, 8'h08);
    port_b_in <= 8'hEE;
    settle(5);
    chk("no_gie", 8'h00, {7'h00, port_change_irq});
    rd(`MSG_ADDR_IRQ_CTRL); chk("flag", 8'h09, d);
    // A clear while the mismatch lasts must lose to the set.
    wr(`MSG_ADDR_IRQ_CTRL, 8'h08);
    rd(`MSG_ADDR_IRQ_CTRL); chk("set_wins", 8'h09, d);
  endtask : t_change

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    rst_n = 1'b0; addr = 8'h00; wdata = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
    osc_mode = OSC_EXTERNAL_CLOCK; timer1_osc_enable = 1'b0;
    periph_out_en = 2'b00; periph_out = 2'b00;
    port_a_in = 8'h00; port_b_in = 8'h00;
    mismatches = 0; checked = 0; cycles = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_analog();
    t_osc();
    t_port_b();
    t_change();
    results();
  end

endmodule : msg_gpio_ports_tb
